// file: rtl/branch_bittest_shift_exec.sv
// Notes on behaviour
// [RULE1] compares subtract, set ZNVCH, drop result
// [RULE2] register bit skip passes next instruction
// [RULE3] io bit skip, flags untouched
// [RULE4] indexed flag branch to pc+k+1
// [RULE5] Z, C, N branches relative
// [RULE6] same-higher/lower alias carry branches
// [RULE7] signed branches test N xor V
// [RULE8] half-carry branches test H
// [RULE9] T flag branches, 1 or 2 cycles
// [RULE10] interrupt-state branches test I
// [RULE11] io set bit, others kept, 2 cycles
// [RULE12] io clear bit, others kept, 2 cycles
// [RULE13] logical shifts fill zero, set ZCNV
// [RULE14] rotate left through carry
// [RULE15] rotate right through carry
// [RULE16] arithmetic shift right keeps sign bit
// [RULE17] bit store copies register bit to T
// [RULE18] bit load copies T into register bit
// [RULE19] flag set/clear change only one flag
// [RULE20] nibble swap, no flags changed
//
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module branch_bittest_shift_exec #(
	parameter int PC_WIDTH = 16
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp
);
	if (PC_WIDTH < branch_bittest_shift_pkg::OFFSET_WIDTH + 1 || PC_WIDTH > 31) begin : g_bad_pc
		$error("PC_WIDTH out of range");
	end

	logic accept;
	logic wr_pending;
	logic rd_pending;
	logic [7:0] addr_q;
	logic [5:0] op_code;
	logic [2:0] op_index;
	logic [7:0] op_imm;
	logic [branch_bittest_shift_pkg::OFFSET_WIDTH-1:0] offset;
	logic [7:0] operand_d;
	logic [7:0] operand_r;
	logic [7:0] io_value;
	logic [7:0] status_flags_reg;
	logic [PC_WIDTH-1:0] pc;
	logic next_is_long;
	branch_bittest_shift_pkg::exec_state_type state;
	logic [1:0] count;
	logic go;
	logic commit;
	logic [7:0] result;
	logic [7:0] io_result;
	logic rd_write;
	logic io_write;
	logic taken;
	logic bad_op;
	logic [1:0] cycles;
	logic [7:0] pend_result;
	logic [7:0] pend_io;
	logic [7:0] pend_flags;
	logic [PC_WIDTH-1:0] pend_pc;
	logic pend_rd_write;
	logic pend_io_write;
	logic pend_taken;
	logic pend_bad_op;
	logic [1:0] pend_cycles;
	logic [7:0] next_result;
	logic [7:0] next_io;
	logic [7:0] next_flags;
	logic [PC_WIDTH-1:0] next_pc;
	logic next_rd_write;
	logic next_io_write;
	logic next_taken;
	logic next_bad_op;
	logic [1:0] next_cycles;
	logic [31:0] next_rdata;

	assign accept = hready && hsel && htrans[1];
	assign go = wr_pending && addr_q == branch_bittest_shift_pkg::ADDR_CTRL && hwdata[0]
		&& state == branch_bittest_shift_pkg::exec_idle;
	assign commit = state == branch_bittest_shift_pkg::exec_run && count == 2'h1;

	// reads take one wait state so a write just before is seen
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pending <= 1'b0;
			rd_pending <= 1'b0;
			addr_q <= 8'h00;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pending <= accept && hwrite && hsize == branch_bittest_shift_pkg::HSIZE_WORD;
			rd_pending <= accept && !hwrite;
			hreadyout <= !(accept && !hwrite);
			hresp <= 1'b0;
			if (accept) begin
				addr_q <= haddr[7:0];
			end
		end
	end

	always_comb begin
		next_rdata = 32'h0000_0000;
		if (addr_q == branch_bittest_shift_pkg::ADDR_OP) begin
			next_rdata[branch_bittest_shift_pkg::OP_CODE_LSB +: 6] = op_code;
			next_rdata[branch_bittest_shift_pkg::OP_INDEX_LSB +: 3] = op_index;
			next_rdata[branch_bittest_shift_pkg::OP_IMM_LSB +: 8] = op_imm;
		end else if (addr_q == branch_bittest_shift_pkg::ADDR_OFFSET) begin
			next_rdata[branch_bittest_shift_pkg::OFFSET_WIDTH-1:0] = offset;
		end else if (addr_q == branch_bittest_shift_pkg::ADDR_OPERAND_D) begin
			next_rdata[7:0] = operand_d;
		end else if (addr_q == branch_bittest_shift_pkg::ADDR_OPERAND_R) begin
			next_rdata[7:0] = operand_r;
		end else if (addr_q == branch_bittest_shift_pkg::ADDR_IO_VALUE) begin
			next_rdata[7:0] = io_value;
		end else if (addr_q == branch_bittest_shift_pkg::ADDR_STATUS) begin
			next_rdata[7:0] = status_flags_reg;
		end else if (addr_q == branch_bittest_shift_pkg::ADDR_PC) begin
			next_rdata[PC_WIDTH-1:0] = pc;
		end else if (addr_q == branch_bittest_shift_pkg::ADDR_NEXT_LEN) begin
			next_rdata[0] = next_is_long;
		end else if (addr_q == branch_bittest_shift_pkg::ADDR_RESULT) begin
			next_rdata[7:0] = result;
			next_rdata[branch_bittest_shift_pkg::RES_IO_LSB +: 8] = io_result;
			next_rdata[branch_bittest_shift_pkg::RES_RD_WRITE] = rd_write;
			next_rdata[branch_bittest_shift_pkg::RES_IO_WRITE] = io_write;
			next_rdata[branch_bittest_shift_pkg::RES_TAKEN] = taken;
			next_rdata[branch_bittest_shift_pkg::RES_BAD_OP] = bad_op;
			next_rdata[branch_bittest_shift_pkg::RES_CYCLES_LSB +: 2] = cycles;
			next_rdata[branch_bittest_shift_pkg::RES_BUSY] = state == branch_bittest_shift_pkg::exec_run;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_pending) begin
			hrdata <= next_rdata;
		end
	end

	// instruction and operand registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			op_code <= 6'h00;
			op_index <= 3'h0;
			op_imm <= branch_bittest_shift_pkg::DATA_RESET;
			offset <= 7'h00;
			operand_d <= branch_bittest_shift_pkg::DATA_RESET;
			operand_r <= branch_bittest_shift_pkg::DATA_RESET;
			io_value <= branch_bittest_shift_pkg::DATA_RESET;
			next_is_long <= 1'b0;
		end else if (wr_pending) begin
			if (addr_q == branch_bittest_shift_pkg::ADDR_OP) begin
				op_code <= hwdata[branch_bittest_shift_pkg::OP_CODE_LSB +: 6];
				op_index <= hwdata[branch_bittest_shift_pkg::OP_INDEX_LSB +: 3];
				op_imm <= hwdata[branch_bittest_shift_pkg::OP_IMM_LSB +: 8];
			end else if (addr_q == branch_bittest_shift_pkg::ADDR_OFFSET) begin
				offset <= hwdata[branch_bittest_shift_pkg::OFFSET_WIDTH-1:0];
			end else if (addr_q == branch_bittest_shift_pkg::ADDR_OPERAND_D) begin
				operand_d <= hwdata[7:0];
			end else if (addr_q == branch_bittest_shift_pkg::ADDR_OPERAND_R) begin
				operand_r <= hwdata[7:0];
			end else if (addr_q == branch_bittest_shift_pkg::ADDR_IO_VALUE) begin
				io_value <= hwdata[7:0];
			end else if (addr_q == branch_bittest_shift_pkg::ADDR_NEXT_LEN) begin
				next_is_long <= hwdata[0];
			end
		end
	end

	always_comb begin
		logic [8:0] diff;
		logic [7:0] sub_b;
		logic [7:0] mask;
		logic [PC_WIDTH-1:0] step;
		logic branch_op;
		logic branch_cond;
		logic skip_op;
		logic skip_cond;
		logic shift_op;
		logic shift_carry;
		diff = 9'h000;
		sub_b = operand_r;
		mask = 8'h01 << op_index;
		step = {{(PC_WIDTH-branch_bittest_shift_pkg::OFFSET_WIDTH){offset[6]}}, offset};
		branch_op = 1'b0;
		branch_cond = 1'b0;
		skip_op = 1'b0;
		skip_cond = 1'b0;
		shift_op = 1'b0;
		shift_carry = 1'b0;
		next_result = operand_d;
		next_io = io_value;
		next_flags = status_flags_reg;
		next_pc = PC_WIDTH'(pc + 1'b1);
		next_rd_write = 1'b0;
		next_io_write = 1'b0;
		next_taken = 1'b0;
		next_bad_op = 1'b0;
		next_cycles = branch_bittest_shift_pkg::CYCLES_SINGLE;
		case (branch_bittest_shift_pkg::op_type'(op_code))
			branch_bittest_shift_pkg::no_operation_op: begin
			end
			// [RULE1] subtract, with borrow only for compare-with-carry
			branch_bittest_shift_pkg::compare_with_carry_op,
			branch_bittest_shift_pkg::compare_immediate_op: begin
				if (branch_bittest_shift_pkg::op_type'(op_code) == branch_bittest_shift_pkg::compare_immediate_op) begin
					sub_b = op_imm;
					diff = {1'b0, operand_d} - {1'b0, sub_b};
				end else begin
					diff = {1'b0, operand_d} - {1'b0, sub_b} - {8'h00, status_flags_reg[branch_bittest_shift_pkg::FLAG_C]};
				end
				next_flags[branch_bittest_shift_pkg::FLAG_C] = diff[8];
				next_flags[branch_bittest_shift_pkg::FLAG_Z] = diff[7:0] == 8'h00;
				next_flags[branch_bittest_shift_pkg::FLAG_N] = diff[7];
				next_flags[branch_bittest_shift_pkg::FLAG_V] = (operand_d[7] & ~sub_b[7] & ~diff[7])
					| (~operand_d[7] & sub_b[7] & diff[7]);
				next_flags[branch_bittest_shift_pkg::FLAG_H] = (~operand_d[3] & sub_b[3])
					| (sub_b[3] & diff[3]) | (diff[3] & ~operand_d[3]);
			end
			// [RULE2] register bit skip
			branch_bittest_shift_pkg::skip_reg_bit_clear_op: begin
				skip_op = 1'b1;
				skip_cond = !operand_r[op_index];
			end
			branch_bittest_shift_pkg::skip_reg_bit_set_op: begin
				skip_op = 1'b1;
				skip_cond = operand_r[op_index];
			end
			// [RULE3] io bit skip
			branch_bittest_shift_pkg::skip_io_bit_clear_op: begin
				skip_op = 1'b1;
				skip_cond = !io_value[op_index];
			end
			branch_bittest_shift_pkg::skip_io_bit_set_op: begin
				skip_op = 1'b1;
				skip_cond = io_value[op_index];
			end
			// [RULE4] indexed status bit
			branch_bittest_shift_pkg::branch_flag_set_op: begin
				branch_op = 1'b1;
				branch_cond = status_flags_reg[op_index];
			end
			branch_bittest_shift_pkg::branch_flag_clear_op: begin
				branch_op = 1'b1;
				branch_cond = !status_flags_reg[op_index];
			end
			// [RULE5] zero and minus tests
			branch_bittest_shift_pkg::branch_equal_op: begin
				branch_op = 1'b1;
				branch_cond = status_flags_reg[branch_bittest_shift_pkg::FLAG_Z];
			end
			branch_bittest_shift_pkg::branch_not_equal_op: begin
				branch_op = 1'b1;
				branch_cond = !status_flags_reg[branch_bittest_shift_pkg::FLAG_Z];
			end
			branch_bittest_shift_pkg::branch_minus_op: begin
				branch_op = 1'b1;
				branch_cond = status_flags_reg[branch_bittest_shift_pkg::FLAG_N];
			end
			branch_bittest_shift_pkg::branch_plus_op: begin
				branch_op = 1'b1;
				branch_cond = !status_flags_reg[branch_bittest_shift_pkg::FLAG_N];
			end
			// [RULE5] [RULE6] carry tests and aliases
			branch_bittest_shift_pkg::branch_carry_set_op,
			branch_bittest_shift_pkg::branch_lower_op: begin
				branch_op = 1'b1;
				branch_cond = status_flags_reg[branch_bittest_shift_pkg::FLAG_C];
			end
			branch_bittest_shift_pkg::branch_carry_clear_op,
			branch_bittest_shift_pkg::branch_same_higher_op: begin
				branch_op = 1'b1;
				branch_cond = !status_flags_reg[branch_bittest_shift_pkg::FLAG_C];
			end
			// [RULE7] signed compare result
			branch_bittest_shift_pkg::branch_signed_ge_op: begin
				branch_op = 1'b1;
				branch_cond = !(status_flags_reg[branch_bittest_shift_pkg::FLAG_N]
					^ status_flags_reg[branch_bittest_shift_pkg::FLAG_V]);
			end
			branch_bittest_shift_pkg::branch_signed_lt_op: begin
				branch_op = 1'b1;
				branch_cond = status_flags_reg[branch_bittest_shift_pkg::FLAG_N]
					^ status_flags_reg[branch_bittest_shift_pkg::FLAG_V];
			end
			// [RULE8] half carry tests
			branch_bittest_shift_pkg::branch_half_carry_set_op: begin
				branch_op = 1'b1;
				branch_cond = status_flags_reg[branch_bittest_shift_pkg::FLAG_H];
			end
			branch_bittest_shift_pkg::branch_half_carry_clear_op: begin
				branch_op = 1'b1;
				branch_cond = !status_flags_reg[branch_bittest_shift_pkg::FLAG_H];
			end
			// [RULE9] T flag tests
			branch_bittest_shift_pkg::branch_tflag_set_op: begin
				branch_op = 1'b1;
				branch_cond = status_flags_reg[branch_bittest_shift_pkg::FLAG_T];
			end
			branch_bittest_shift_pkg::branch_tflag_clear_op: begin
				branch_op = 1'b1;
				branch_cond = !status_flags_reg[branch_bittest_shift_pkg::FLAG_T];
			end
			// [RULE10] interrupt enable tests
			branch_bittest_shift_pkg::branch_irq_enabled_op: begin
				branch_op = 1'b1;
				branch_cond = status_flags_reg[branch_bittest_shift_pkg::FLAG_I];
			end
			branch_bittest_shift_pkg::branch_irq_disabled_op: begin
				branch_op = 1'b1;
				branch_cond = !status_flags_reg[branch_bittest_shift_pkg::FLAG_I];
			end
			// [RULE11] read-modify-write one bit
			branch_bittest_shift_pkg::io_bit_set_op: begin
				next_io = io_value | mask;
				next_io_write = 1'b1;
				next_cycles = branch_bittest_shift_pkg::CYCLES_IO_WRITE;
			end
			// [RULE12] read-modify-write one bit
			branch_bittest_shift_pkg::io_bit_clear_op: begin
				next_io = io_value & ~mask;
				next_io_write = 1'b1;
				next_cycles = branch_bittest_shift_pkg::CYCLES_IO_WRITE;
			end
			// [RULE13] zero fill shifts
			branch_bittest_shift_pkg::shift_left_logical_op: begin
				shift_op = 1'b1;
				shift_carry = operand_d[7];
				next_result = {operand_d[6:0], 1'b0};
			end
			branch_bittest_shift_pkg::shift_right_logical_op: begin
				shift_op = 1'b1;
				shift_carry = operand_d[0];
				next_result = {1'b0, operand_d[7:1]};
			end
			// [RULE14] old carry into bit 0
			branch_bittest_shift_pkg::rotate_left_carry_op: begin
				shift_op = 1'b1;
				shift_carry = operand_d[7];
				next_result = {operand_d[6:0], status_flags_reg[branch_bittest_shift_pkg::FLAG_C]};
			end
			// [RULE15] old carry into bit 7
			branch_bittest_shift_pkg::rotate_right_carry_op: begin
				shift_op = 1'b1;
				shift_carry = operand_d[0];
				next_result = {status_flags_reg[branch_bittest_shift_pkg::FLAG_C], operand_d[7:1]};
			end
			// [RULE16] sign bit kept
			branch_bittest_shift_pkg::shift_right_arith_op: begin
				shift_op = 1'b1;
				shift_carry = operand_d[0];
				next_result = {operand_d[7], operand_d[7:1]};
			end
			// [RULE20] nibble exchange
			branch_bittest_shift_pkg::swap_nibbles_op: begin
				next_result = {operand_d[3:0], operand_d[7:4]};
				next_rd_write = 1'b1;
			end
			// [RULE19] indexed flag write
			branch_bittest_shift_pkg::flag_set_indexed_op: begin
				next_flags[op_index] = 1'b1;
			end
			branch_bittest_shift_pkg::flag_clear_indexed_op: begin
				next_flags[op_index] = 1'b0;
			end
			// [RULE17] register bit to T
			branch_bittest_shift_pkg::bit_to_tflag_op: begin
				next_flags[branch_bittest_shift_pkg::FLAG_T] = operand_r[op_index];
			end
			// [RULE18] T into register bit
			branch_bittest_shift_pkg::tflag_to_bit_op: begin
				next_result[op_index] = status_flags_reg[branch_bittest_shift_pkg::FLAG_T];
				next_rd_write = 1'b1;
			end
			// [RULE19] dedicated flag writes
			branch_bittest_shift_pkg::carry_set_op: begin
				next_flags[branch_bittest_shift_pkg::FLAG_C] = 1'b1;
			end
			branch_bittest_shift_pkg::carry_clear_op: begin
				next_flags[branch_bittest_shift_pkg::FLAG_C] = 1'b0;
			end
			branch_bittest_shift_pkg::negative_set_op: begin
				next_flags[branch_bittest_shift_pkg::FLAG_N] = 1'b1;
			end
			branch_bittest_shift_pkg::negative_clear_op: begin
				next_flags[branch_bittest_shift_pkg::FLAG_N] = 1'b0;
			end
			branch_bittest_shift_pkg::zero_flag_set_op: begin
				next_flags[branch_bittest_shift_pkg::FLAG_Z] = 1'b1;
			end
			branch_bittest_shift_pkg::zero_flag_clear_op: begin
				next_flags[branch_bittest_shift_pkg::FLAG_Z] = 1'b0;
			end
			branch_bittest_shift_pkg::global_irq_enable_op: begin
				next_flags[branch_bittest_shift_pkg::FLAG_I] = 1'b1;
			end
			default: begin
				next_bad_op = 1'b1;
			end
		endcase
		// [RULE13] shift flag update, V is N xor C
		if (shift_op) begin
			next_rd_write = 1'b1;
			next_flags[branch_bittest_shift_pkg::FLAG_C] = shift_carry;
			next_flags[branch_bittest_shift_pkg::FLAG_Z] = next_result == 8'h00;
			next_flags[branch_bittest_shift_pkg::FLAG_N] = next_result[7];
			next_flags[branch_bittest_shift_pkg::FLAG_V] = next_result[7] ^ shift_carry;
		end
		// [RULE4] relative target and 1/2 cycles
		if (branch_op && branch_cond) begin
			next_taken = 1'b1;
			next_pc = PC_WIDTH'(pc + step + 1'b1);
			next_cycles = branch_bittest_shift_pkg::CYCLES_TAKEN;
		end
		// [RULE2] [RULE3] skip over one or two words
		if (skip_op && skip_cond) begin
			next_taken = 1'b1;
			if (next_is_long) begin
				next_pc = PC_WIDTH'(pc + 2'h3);
				next_cycles = branch_bittest_shift_pkg::CYCLES_SKIP_LONG;
			end else begin
				next_pc = PC_WIDTH'(pc + 2'h2);
				next_cycles = branch_bittest_shift_pkg::CYCLES_TAKEN;
			end
		end
	end

	// results held back until the cycle count has run out
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= branch_bittest_shift_pkg::exec_idle;
			count <= 2'h0;
			pend_result <= branch_bittest_shift_pkg::DATA_RESET;
			pend_io <= branch_bittest_shift_pkg::DATA_RESET;
			pend_flags <= branch_bittest_shift_pkg::STATUS_RESET;
			pend_pc <= '0;
			pend_rd_write <= 1'b0;
			pend_io_write <= 1'b0;
			pend_taken <= 1'b0;
			pend_bad_op <= 1'b0;
			pend_cycles <= 2'h0;
		end else begin
			case (state)
				branch_bittest_shift_pkg::exec_idle: begin
					if (go) begin
						state <= branch_bittest_shift_pkg::exec_run;
						count <= next_cycles;
						pend_result <= next_result;
						pend_io <= next_io;
						pend_flags <= next_flags;
						pend_pc <= next_pc;
						pend_rd_write <= next_rd_write;
						pend_io_write <= next_io_write;
						pend_taken <= next_taken;
						pend_bad_op <= next_bad_op;
						pend_cycles <= next_cycles;
					end
				end
				branch_bittest_shift_pkg::exec_run: begin
					count <= 2'(count - 1'b1);
					if (commit) begin
						state <= branch_bittest_shift_pkg::exec_idle;
					end
				end
				default: begin
					state <= branch_bittest_shift_pkg::exec_idle;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			result <= branch_bittest_shift_pkg::DATA_RESET;
			io_result <= branch_bittest_shift_pkg::DATA_RESET;
			rd_write <= 1'b0;
			io_write <= 1'b0;
			taken <= 1'b0;
			bad_op <= 1'b0;
			cycles <= 2'h0;
		end else if (commit) begin
			result <= pend_result;
			io_result <= pend_io;
			rd_write <= pend_rd_write;
			io_write <= pend_io_write;
			taken <= pend_taken;
			bad_op <= pend_bad_op;
			cycles <= pend_cycles;
		end
	end

	// commit wins over a software write in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_flags_reg <= branch_bittest_shift_pkg::STATUS_RESET;
		end else if (commit) begin
			status_flags_reg <= pend_flags;
		end else if (wr_pending && addr_q == branch_bittest_shift_pkg::ADDR_STATUS) begin
			status_flags_reg <= hwdata[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pc <= '0;
		end else if (commit) begin
			pc <= pend_pc;
		end else if (wr_pending && addr_q == branch_bittest_shift_pkg::ADDR_PC) begin
			pc <= hwdata[PC_WIDTH-1:0];
		end
	end
endmodule : branch_bittest_shift_exec

`default_nettype wire

// file: include/branch_bittest_shift_pkg.sv
package branch_bittest_shift_pkg;
	localparam logic [7:0] ADDR_OP = 8'h00;
	localparam logic [7:0] ADDR_OFFSET = 8'h04;
	localparam logic [7:0] ADDR_OPERAND_D = 8'h08;
	localparam logic [7:0] ADDR_OPERAND_R = 8'h0c;
	localparam logic [7:0] ADDR_IO_VALUE = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam logic [7:0] ADDR_PC = 8'h18;
	localparam logic [7:0] ADDR_NEXT_LEN = 8'h1c;
	localparam logic [7:0] ADDR_CTRL = 8'h20;
	localparam logic [7:0] ADDR_RESULT = 8'h24;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam int OP_CODE_LSB = 0;
	localparam int OP_CODE_WIDTH = 6;
	localparam int OP_INDEX_LSB = 8;
	localparam int OP_IMM_LSB = 16;
	localparam int OFFSET_WIDTH = 7;
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;
	localparam int RES_IO_LSB = 8;
	localparam int RES_RD_WRITE = 16;
	localparam int RES_IO_WRITE = 17;
	localparam int RES_TAKEN = 18;
	localparam int RES_BAD_OP = 19;
	localparam int RES_CYCLES_LSB = 20;
	localparam int RES_BUSY = 31;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [1:0] CYCLES_SINGLE = 2'h1;
	localparam logic [1:0] CYCLES_TAKEN = 2'h2;
	localparam logic [1:0] CYCLES_SKIP_LONG = 2'h3;
	localparam logic [1:0] CYCLES_IO_WRITE = 2'h2;

	typedef enum logic [5:0] {
		no_operation_op, compare_with_carry_op, compare_immediate_op,
		skip_reg_bit_clear_op, skip_reg_bit_set_op, skip_io_bit_clear_op, skip_io_bit_set_op,
		branch_flag_set_op, branch_flag_clear_op, branch_equal_op, branch_not_equal_op,
		branch_carry_set_op, branch_carry_clear_op, branch_same_higher_op, branch_lower_op,
		branch_minus_op, branch_plus_op, branch_signed_ge_op, branch_signed_lt_op,
		branch_half_carry_set_op, branch_half_carry_clear_op, branch_tflag_set_op,
		branch_tflag_clear_op, branch_irq_enabled_op, branch_irq_disabled_op,
		io_bit_set_op, io_bit_clear_op, shift_left_logical_op, shift_right_logical_op,
		rotate_left_carry_op, rotate_right_carry_op, shift_right_arith_op, swap_nibbles_op,
		flag_set_indexed_op, flag_clear_indexed_op, bit_to_tflag_op, tflag_to_bit_op,
		carry_set_op, carry_clear_op, negative_set_op, negative_clear_op,
		zero_flag_set_op, zero_flag_clear_op, global_irq_enable_op
	} op_type;

	typedef enum logic [0:0] {
		exec_idle,
		exec_run
	} exec_state_type;
endpackage : branch_bittest_shift_pkg

// file: bench/branch_bittest_shift_checker.sv
`timescale 1ns/1ps
`default_nettype none
module branch_bittest_shift_checker (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic rd_go;
	assign rd_go = hsel && htrans[1] && !hwrite && hready;
	a_resp_okay: assert property (hresp == 1'b0) else $error("resp not okay");
	a_read_wait: assert property (rd_go |=> !hreadyout) else $error("no read wait");
	a_wait_single: assert property (!hreadyout |=> hreadyout) else $error("wait too long");
	a_write_no_wait: assert property (hsel && htrans[1] && hwrite && hready |=> hreadyout)
		else $error("write waited");
	a_idle_ready: assert property (htrans == 2'h0 |=> hreadyout) else $error("idle waited");
	a_rdata_hold: assert property ($changed(hrdata) |-> $rose(hreadyout))
		else $error("rdata moved");
	a_ctrl_reads_zero: assert property (rd_go && haddr[7:0] == branch_bittest_shift_pkg::ADDR_CTRL
		|=> ##1 hrdata == 32'h0) else $error("ctrl read nonzero");
	a_unmapped_zero: assert property (rd_go && haddr[7:0] > branch_bittest_shift_pkg::ADDR_RESULT
		|=> ##1 hrdata == 32'h0) else $error("unmapped nonzero");
endmodule : branch_bittest_shift_checker
bind branch_bittest_shift_exec branch_bittest_shift_checker chk_i (.hclk, .hresetn, .hsel,
	.haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp);
`default_nettype wire

// file: bench/test_branch_bittest_shift_exec.sv
`timescale 1ns/1ps
`default_nettype none
module test_branch_bittest_shift_exec;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, res, sr, pcv, tmp;
	logic [1:0] htrans;
	int err_count, num_checks;
	branch_bittest_shift_exec dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(branch_bittest_shift_pkg::HSIZE_WORD), .hwdata, .hready(hreadyout), .hrdata,
		.hreadyout, .hresp);
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		rd = hrdata;
	endtask : xfer
	// operands latched at go, so all set-up writes precede ctrl
	task automatic run(input logic [5:0] op, input logic [2:0] ix, input logic [7:0] d, r, io, st,
			input logic nl);
		logic [31:0] v [8];
		int n;
		v = '{{8'h0, r, 5'h0, ix, 2'h0, op}, 32'h5, {24'h0, d}, {24'h0, r}, {24'h0, io},
			{24'h0, st}, 32'h40, {31'h0, nl}};
		for (int i = 0; i < 8; i++) xfer(1'b1, 8'(4 * i), v[i], tmp);
		xfer(1'b1, branch_bittest_shift_pkg::ADDR_CTRL, 32'h1, tmp);
		n = 0;
		res = 32'h80000000;
		while (res[31] && n < 20) begin
			xfer(1'b0, branch_bittest_shift_pkg::ADDR_RESULT, '0, res);
			n++;
		end
		chk("busy", res[31], '0);
		xfer(1'b0, branch_bittest_shift_pkg::ADDR_STATUS, '0, sr);
		xfer(1'b0, branch_bittest_shift_pkg::ADDR_PC, '0, pcv);
	endtask : run
	task automatic t_compare;
		run(6'h1, '0, 8'h10, 8'h10, '0, 8'h03, '0);
		chk("cpc flags", sr, 32'h25);
		chk("cpc res", res[21:16], 6'h10);
		run(6'h2, '0, 8'h80, 8'h01, '0, 8'h00, '0);
		chk("cpi flags", sr, 32'h28);
	endtask : t_compare
	task automatic t_skip;
		logic [7:0] v;
		logic m, nl;
		for (int op = 3; op <= 6; op++) begin
			for (int s = 0; s < 2; s++) begin
				v = s ? 8'h20 : 8'hdf;
				m = op[0] ? !v[5] : v[5];
				nl = s[0] ^ op[1];
				run(6'(op), 3'h5, '0, v, v, 8'h3c, nl);
				chk("skip pc", pcv, m ? 32'h42 + nl : 32'h41);
				chk("skip res", res[21:18], {m ? 2'h2 + nl : 2'h1, 1'b0, m});
				chk("skip flags", sr, 32'h3c);
			end
		end
	endtask : t_skip
	task automatic t_branch;
		logic [7:0] st;
		logic tk;
		for (int op = 7; op <= 24; op++) begin
			for (int s = 0; s < 2; s++) begin
				st = s ? 8'ha9 : 8'h5e;
				case (op)
					7, 23: tk = st[7];
					8, 12, 13: tk = !st[0];
					9: tk = st[1];
					10: tk = !st[1];
					11, 14: tk = st[0];
					15: tk = st[2];
					16: tk = !st[2];
					17: tk = !(st[2] ^ st[3]);
					18: tk = st[2] ^ st[3];
					19: tk = st[5];
					20: tk = !st[5];
					21: tk = st[6];
					22: tk = !st[6];
					default: tk = !st[7];
				endcase
				run(6'(op), 3'(op), '0, '0, '0, st, '0);
				chk("br pc", pcv, tk ? 32'h46 : 32'h41);
				chk("br res", res[21:18], {tk ? 2'h2 : 2'h1, 1'b0, tk});
				chk("br flags", sr, st);
			end
		end
	endtask : t_branch
	task automatic t_io;
		run(6'h19, 3'h3, '0, '0, 8'h00, 8'h81, '0);
		chk("io set", res[21:8], {2'h2, 4'h2, 8'h08});
		chk("io set flags", sr, 32'h81);
		run(6'h1a, 3'h7, '0, '0, 8'hff, 8'h81, '0);
		chk("io clr", res[21:8], {2'h2, 4'h2, 8'h7f});
		chk("io clr flags", sr, 32'h81);
	endtask : t_io
	task automatic t_shift;
		logic [7:0] rs [6] = '{8'h2c, 8'h4b, 8'h2d, 8'hcb, 8'hcb, 8'h69};
		logic [7:0] fs [6] = '{8'h09, 8'h00, 8'h09, 8'h0c, 8'h0c, 8'h01};
		for (int i = 0; i < 6; i++) begin
			run(6'(27 + i), '0, 8'h96, '0, '0, 8'h01, '0);
			chk("shift rd", res[7:0], rs[i]);
			chk("shift flags", sr, fs[i]);
			chk("shift cyc", res[21:20], 2'h1);
		end
	endtask : t_shift
	task automatic t_flags;
		int fb [4] = '{0, 2, 1, 7};
		logic [7:0] st;
		for (int op = 33; op <= 43; op++) begin
			if (op != 35 && op != 36) begin
				st = op[0] ? 8'h00 : 8'hff;
				run(6'(op), 3'h6, '0, '0, '0, st, '0);
				chk("flag", sr, st ^ (8'h01 << (op < 35 ? 6 : fb[(op - 37) / 2])));
			end
		end
		run(6'h23, 3'h6, '0, 8'h40, '0, 8'h00, '0);
		chk("bst", sr, 32'h40);
		run(6'h24, 3'h2, 8'h00, '0, '0, 8'h40, '0);
		chk("bld", {sr[7:0], res[7:0]}, 16'h4004);
	endtask : t_flags
	task automatic give_verdict;
		if (err_count == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : give_verdict
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		xfer(1'b0, branch_bittest_shift_pkg::ADDR_STATUS, '0, tmp);
		chk("status reset", tmp, '0);
		xfer(1'b0, 8'h30, '0, tmp);
		chk("unmapped", tmp, '0);
		t_compare;
		t_skip;
		t_branch;
		t_io;
		t_shift;
		t_flags;
		give_verdict;
	end
	// some 70 runs of about 30 cycles each; ample margin
	initial begin
		#200000;
		err_count++;
		give_verdict;
	end
endmodule : test_branch_bittest_shift_exec
`default_nettype wire
